// ===== hdl/ccpm_pkg.sv
// Constants, types and mode decode for the charge port mode/status control
package ccpm_pkg;

   // -------------------------------------------------------------
   // Clock and timing
   // -------------------------------------------------------------
   localparam int CLK_HZ          = 50_000_000;
   localparam int CYC_PER_MS      = CLK_HZ / 1000;
   localparam int TMR_W           = 28;
   localparam int ASSERT_QUAL_MS  = 200;
   localparam int RELEASE_QUAL_MS = 3000;
   localparam int CL_DEGLITCH_MS  = 8;
   localparam int DISCH_MS        = 100;
   localparam int V12_MS          = 50;
   localparam int DIV2_TEST_MS    = 100;
   // Least times: whole milliseconds divide evenly into cycles
   localparam int ASSERT_QUAL_CYC  = ASSERT_QUAL_MS * CYC_PER_MS;
   localparam int RELEASE_QUAL_CYC = RELEASE_QUAL_MS * CYC_PER_MS;
   localparam int CL_DEGLITCH_CYC  = CL_DEGLITCH_MS * CYC_PER_MS;
   localparam logic [TMR_W-1:0] DISCH_CYC     = TMR_W'(DISCH_MS * CYC_PER_MS);
   localparam logic [TMR_W-1:0] V12_CYC       = TMR_W'(V12_MS * CYC_PER_MS);
   localparam logic [TMR_W-1:0] DIV2_TEST_CYC =
      TMR_W'(DIV2_TEST_MS * CYC_PER_MS);

   // -------------------------------------------------------------
   // Modes and dedicated-port schemes
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      M_DISCHARGE   = 3'b000,
      M_AUTOMATIC_DEDICATED_MODE    = 3'b001,
      M_SDP_BASIC   = 3'b010,
      M_FORCED_SHORTED_DEDICATED_MODE = 3'b011,
      M_DCP_DIV1    = 3'b100,
      M_SDP_ALT     = 3'b101,
      M_CDP         = 3'b110
   } ccpm_mode_e;

   typedef enum logic [2:0] {
      SCH_DIV1         = 3'b000,
      SCH_ATTACH_DISCH = 3'b001,
      SCH_V12          = 3'b010,
      SCH_BC12         = 3'b011,
      SCH_DIV2_TEST    = 3'b100,
      SCH_DIV2         = 3'b101,
      SCH_NONE         = 3'b110
   } ccpm_scheme_e;

   // -------------------------------------------------------------
   // Pin group, all asynchronous to i_mclk
   // -------------------------------------------------------------
   typedef struct packed {
      logic control_pin_one;
      logic control_pin_two;
      logic control_pin_three;
      logic limit_select_input;
      logic enable;
      logic load_above_trip;
      logic load_below_release;
      logic in_current_limit;
      logic temp_over_135;
      logic temp_over_155;
      logic temp_cooled;
      logic vin_above_on;
      logic vin_above_off;
      logic primary_detect;
      logic dcp_attach;
      logic data_released;
      logic over_750ma;
   } ccpm_pins_s;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam ccpm_mode_e   RST_MODE   = M_DISCHARGE;
   localparam ccpm_scheme_e RST_SCHEME = SCH_DIV1;
   localparam logic         RST_OE_N   = 1'h1;

   function automatic ccpm_mode_e ccpm_decode_mode(input logic [3:0] pins);
      ccpm_mode_e m;
      m = M_DISCHARGE;
      case (pins[3:1])
         3'h0:    m = M_DISCHARGE;
         3'h1:    m = M_AUTOMATIC_DEDICATED_MODE;
         3'h3:    m = M_AUTOMATIC_DEDICATED_MODE;
         3'h2:    m = M_SDP_BASIC;
         3'h6:    m = M_SDP_BASIC;
         3'h4:    m = M_FORCED_SHORTED_DEDICATED_MODE;
         3'h5:    m = M_DCP_DIV1;
         3'h7:    m = pins[0] ? M_CDP : M_SDP_ALT;
         default: m = M_DISCHARGE;
      endcase
      return m;
   endfunction

endpackage

// ===== hdl/ccpm_qual_timer.sv
// Qualification timer: reports a condition held for a number of cycles
`timescale 1ns/100ps
module ccpm_qual_timer #(
   parameter int CYCLES = 16
) (
   input  wire logic i_mclk,
   input  wire logic i_nrst,
   input  wire logic i_cond,
   output logic      o_done
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         done_r;
   logic         done_nxt;

   // Any drop of the condition restarts the count
   always_comb begin
      cnt_nxt  = cnt_r;
      done_nxt = 1'b0;
      if (!i_cond) begin
         cnt_nxt = '0;
      end else if (cnt_r == LAST) begin
         done_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + W'(1);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign o_done = done_r;

endmodule

// ===== hdl/ccpm_ctrl.sv
// Charge port mode, status, fault and switch control
`timescale 1ns/100ps
module ccpm_ctrl #(
   parameter int ASSERT_CYC  = ccpm_pkg::ASSERT_QUAL_CYC,
   parameter int RELEASE_CYC = ccpm_pkg::RELEASE_QUAL_CYC,
   parameter int DEGLITCH_CYC = ccpm_pkg::CL_DEGLITCH_CYC,
   parameter logic [ccpm_pkg::TMR_W-1:0] DISCH_CYC = ccpm_pkg::DISCH_CYC,
   parameter logic [ccpm_pkg::TMR_W-1:0] V12_CYC   = ccpm_pkg::V12_CYC,
   parameter logic [ccpm_pkg::TMR_W-1:0] DIV2_CYC  = DISCH_CYC
) (
   input  wire logic                 i_mclk,
   input  wire logic                 i_nrst,
   input  wire ccpm_pkg::ccpm_pins_s i_pins,
   output ccpm_pkg::ccpm_mode_e      o_mode,
   output ccpm_pkg::ccpm_scheme_e    o_scheme,
   output logic                      o_switch_on,
   output logic                      o_limit_high,
   output logic                      o_discharge,
   output logic                      o_data_sw_on,
   output logic                      o_status_o,
   output logic                      o_status_oe_n,
   output logic                      o_fault_o,
   output logic                      o_fault_oe_n
);
   import ccpm_pkg::*;

   localparam int TW = TMR_W;

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   ccpm_pins_s meta_r;
   ccpm_pins_s pins_r;

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         meta_r <= '0;
         pins_r <= '0;
      end else begin
         meta_r <= i_pins;
         pins_r <= meta_r;
      end
   end

   // -------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------
   ccpm_mode_e mode_r;
   ccpm_mode_e mode_nxt;
   logic       alt_cdp_swap;
   logic       status_en;
   logic       auto_r;

   always_comb begin
      mode_nxt = ccpm_decode_mode({pins_r.control_pin_one,
                                   pins_r.control_pin_two,
                                   pins_r.control_pin_three,
                                   pins_r.limit_select_input});
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         mode_r <= RST_MODE;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Swapping between these two keeps a synced media device undisturbed
   assign alt_cdp_swap =
      (mode_r == M_SDP_ALT && mode_nxt == M_CDP) ||
      (mode_r == M_CDP && mode_nxt == M_SDP_ALT);
   assign status_en = (mode_r == M_CDP) || (mode_r == M_AUTOMATIC_DEDICATED_MODE) ||
                      (mode_r == M_FORCED_SHORTED_DEDICATED_MODE) || (mode_r == M_DCP_DIV1);
   assign auto_r = (mode_r == M_AUTOMATIC_DEDICATED_MODE);

   // -------------------------------------------------------------
   // Qualification and deglitch timers
   // -------------------------------------------------------------
   logic hi_done;
   logic lo_done;
   logic cl_done;
   logic switch_r;

   ccpm_qual_timer #(.CYCLES(ASSERT_CYC)) u_hi_qual (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_cond (status_en && pins_r.load_above_trip),
      .o_done (hi_done)
   );

   ccpm_qual_timer #(.CYCLES(RELEASE_CYC)) u_lo_qual (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_cond (status_en && pins_r.load_below_release),
      .o_done (lo_done)
   );

   ccpm_qual_timer #(.CYCLES(DEGLITCH_CYC)) u_cl_deglitch (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_cond (pins_r.in_current_limit),
      .o_done (cl_done)
   );

   // -------------------------------------------------------------
   // Port power sharing status
   // -------------------------------------------------------------
   logic pd_prev_r;
   logic pd_evt;
   logic status_oe_n_r;
   logic status_oe_n_nxt;

   assign pd_evt = pins_r.primary_detect && !pd_prev_r;

   // Assert beats release when both land together
   always_comb begin
      status_oe_n_nxt = status_oe_n_r;
      if (!status_en) begin
         status_oe_n_nxt = 1'b1;
      end else if (hi_done) begin
         status_oe_n_nxt = 1'b0;
      end else if (mode_r == M_CDP && pd_evt) begin
         status_oe_n_nxt = 1'b0;
      end else if (lo_done) begin
         status_oe_n_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         pd_prev_r     <= 1'b0;
         status_oe_n_r <= RST_OE_N;
      end else begin
         pd_prev_r     <= pins_r.primary_detect;
         status_oe_n_r <= status_oe_n_nxt;
      end
   end

   // -------------------------------------------------------------
   // Lockout and thermal protection
   // -------------------------------------------------------------
   logic input_undervoltage_lockout_ok_r;
   logic input_undervoltage_lockout_ok_nxt;
   logic therm_off_r;
   logic therm_off_nxt;
   logic therm_set;

   assign therm_set = pins_r.temp_over_155 ||
      (pins_r.temp_over_135 && pins_r.in_current_limit);

   always_comb begin
      input_undervoltage_lockout_ok_nxt = input_undervoltage_lockout_ok_r;
      if (pins_r.vin_above_on) begin
         input_undervoltage_lockout_ok_nxt = 1'b1;
      end else if (!pins_r.vin_above_off) begin
         input_undervoltage_lockout_ok_nxt = 1'b0;
      end
      therm_off_nxt = therm_off_r;
      if (therm_set) begin
         therm_off_nxt = 1'b1;
      end else if (pins_r.temp_cooled) begin
         therm_off_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         input_undervoltage_lockout_ok_r   <= 1'b0;
         therm_off_r <= 1'b0;
      end else begin
         input_undervoltage_lockout_ok_r   <= input_undervoltage_lockout_ok_nxt;
         therm_off_r <= therm_off_nxt;
      end
   end

   // -------------------------------------------------------------
   // Output discharge
   // -------------------------------------------------------------
   ccpm_scheme_e     scheme_r;
   logic [TW-1:0]    disch_cnt_r;
   logic [TW-1:0]    disch_cnt_nxt;
   logic             attach_start;
   logic             disch_start;
   logic             disch_act;

   assign attach_start = auto_r && scheme_r == SCH_DIV1 &&
                         pins_r.dcp_attach;
   assign disch_start = (mode_nxt != mode_r && !alt_cdp_swap) ||
                        attach_start;
   assign disch_act = (disch_cnt_r != '0) || (mode_r == M_DISCHARGE);

   always_comb begin
      disch_cnt_nxt = disch_cnt_r;
      if (disch_start) begin
         disch_cnt_nxt = DISCH_CYC;
      end else if (disch_cnt_r != '0) begin
         disch_cnt_nxt = disch_cnt_r - TW'(1);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         disch_cnt_r <= '0;
      end else begin
         disch_cnt_r <= disch_cnt_nxt;
      end
   end

   // -------------------------------------------------------------
   // Automatic dedicated-port scheme sequencer
   // -------------------------------------------------------------
   ccpm_scheme_e  scheme_nxt;
   logic [TW-1:0] sch_cnt_r;
   logic [TW-1:0] sch_cnt_nxt;

   always_comb begin
      scheme_nxt  = scheme_r;
      sch_cnt_nxt = sch_cnt_r;
      if (!auto_r) begin
         scheme_nxt  = SCH_DIV1;
         sch_cnt_nxt = '0;
      end else begin
         case (scheme_r)
            SCH_DIV1: begin
               if (attach_start) begin
                  scheme_nxt = SCH_ATTACH_DISCH;
               end else if (pins_r.over_750ma) begin
                  scheme_nxt  = SCH_DIV2_TEST;
                  sch_cnt_nxt = DIV2_CYC;
               end
            end
            SCH_ATTACH_DISCH: begin
               if (disch_cnt_r <= TW'(1)) begin
                  scheme_nxt  = SCH_V12;
                  sch_cnt_nxt = V12_CYC;
               end
            end
            SCH_V12: begin
               if (sch_cnt_r <= TW'(1)) begin
                  scheme_nxt = SCH_BC12;
               end else begin
                  sch_cnt_nxt = sch_cnt_r - TW'(1);
               end
            end
            SCH_BC12: begin
               if (pins_r.data_released) begin
                  scheme_nxt = SCH_DIV1;
               end
            end
            SCH_DIV2_TEST: begin
               if (sch_cnt_r <= TW'(1)) begin
                  scheme_nxt = pins_r.over_750ma ? SCH_DIV2 : SCH_DIV1;
               end else begin
                  sch_cnt_nxt = sch_cnt_r - TW'(1);
               end
            end
            SCH_DIV2: begin
               if (!pins_r.over_750ma) begin
                  scheme_nxt = SCH_DIV1;
               end
            end
            default: begin
               scheme_nxt = SCH_DIV1;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         scheme_r  <= RST_SCHEME;
         sch_cnt_r <= '0;
      end else begin
         scheme_r  <= scheme_nxt;
         sch_cnt_r <= sch_cnt_nxt;
      end
   end

   // -------------------------------------------------------------
   // Registered outputs
   // -------------------------------------------------------------
   ccpm_scheme_e scheme_out_r;
   ccpm_scheme_e scheme_out_nxt;
   logic         switch_nxt;
   logic         limit_r;
   logic         limit_nxt;
   logic         discharge_r;
   logic         data_sw_r;
   logic         data_sw_nxt;
   logic         fault_oe_n_r;
   logic         fault_oe_n_nxt;
   logic         pin_low_r;

   always_comb begin
      switch_nxt = input_undervoltage_lockout_ok_r && !therm_off_r && !disch_act;
      // Forced dedicated modes follow limit select
      limit_nxt = pins_r.limit_select_input ||
                  auto_r || mode_r == M_CDP;
      data_sw_nxt = (mode_r == M_CDP || mode_r == M_SDP_BASIC ||
                     mode_r == M_SDP_ALT) && pins_r.enable &&
                    !disch_act;
      fault_oe_n_nxt = !(therm_set || therm_off_r || cl_done);
      case (mode_r)
         M_AUTOMATIC_DEDICATED_MODE:    scheme_out_nxt = scheme_r;
         M_FORCED_SHORTED_DEDICATED_MODE: scheme_out_nxt = SCH_BC12;
         M_DCP_DIV1:    scheme_out_nxt = SCH_DIV1;
         default:       scheme_out_nxt = SCH_NONE;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         switch_r     <= 1'b0;
         limit_r      <= 1'b0;
         discharge_r  <= 1'b0;
         data_sw_r    <= 1'b0;
         fault_oe_n_r <= RST_OE_N;
         scheme_out_r <= SCH_NONE;
         pin_low_r    <= 1'b0;
      end else begin
         switch_r     <= switch_nxt;
         limit_r      <= limit_nxt;
         discharge_r  <= disch_act;
         data_sw_r    <= data_sw_nxt;
         fault_oe_n_r <= fault_oe_n_nxt;
         scheme_out_r <= scheme_out_nxt;
         pin_low_r    <= 1'b0;
      end
   end

   assign o_mode        = mode_r;
   assign o_scheme      = scheme_out_r;
   assign o_switch_on   = switch_r;
   assign o_limit_high  = limit_r;
   assign o_discharge   = discharge_r;
   assign o_data_sw_on  = data_sw_r;
   assign o_status_o    = pin_low_r;
   assign o_status_oe_n = status_oe_n_r;
   assign o_fault_o     = pin_low_r;
   assign o_fault_oe_n  = fault_oe_n_r;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   status_assert_a: assert property (
      status_en && mode_nxt == mode_r && hi_done |=> !o_status_oe_n)
      else $error("status not asserted after qualification");
   status_pd_a: assert property (
      mode_r == M_CDP && mode_nxt == M_CDP && pd_evt |=> !o_status_oe_n)
      else $error("status not asserted on primary detection");
   status_release_a: assert property (
      status_en && mode_nxt == mode_r && lo_done && !hi_done &&
      !(mode_r == M_CDP && pd_evt) |=> o_status_oe_n)
      else $error("status not released after qualification");
   limit_high_a: assert property (
      mode_r == M_CDP || mode_r == M_AUTOMATIC_DEDICATED_MODE |=> o_limit_high)
      else $error("charging port not on high limit");
   limit_low_a: assert property (
      mode_r == M_SDP_ALT && !pins_r.limit_select_input |=> !o_limit_high)
      else $error("standard port not on low limit");
   no_disch_swap_a: assert property (
      mode_r == M_SDP_ALT && mode_nxt == M_CDP && disch_cnt_r == '0
      |=> disch_cnt_r == '0)
      else $error("discharge on alternate to charging swap");
   therm_trip_a: assert property (
      therm_set |=> ##1 !o_switch_on && !o_fault_oe_n)
      else $error("thermal trip did not cut switch");
   therm_hold_a: assert property (
      therm_off_r && !pins_r.temp_cooled |=> therm_off_r)
      else $error("thermal latch released before cooling");
   fault_dg_a: assert property (
      $rose(pins_r.in_current_limit) && !therm_set && !therm_off_r
      |=> o_fault_oe_n)
      else $error("current limit reported without deglitch");
   input_undervoltage_lockout_gate_a: assert property (
      !input_undervoltage_lockout_ok_r |=> !o_switch_on)
      else $error("switch on during lockout");
   bc12_hold_a: assert property (
      auto_r && scheme_r == SCH_BC12 && !pins_r.data_released &&
      mode_nxt == mode_r |=> scheme_r == SCH_BC12)
      else $error("left BC1.2 without data release");
   div2_drop_a: assert property (
      auto_r && scheme_r == SCH_DIV2 && !pins_r.over_750ma
      |=> scheme_r == SCH_DIV1)
      else $error("second divider kept without high current");
   data_sw_a: assert property (
      disch_act || !pins_r.enable |=> !o_data_sw_on)
      else $error("data switch closed while not allowed");

   status_seen_c: cover property (status_en ##1 !o_status_oe_n);
   therm_cycle_c: cover property (therm_off_r ##1 !therm_off_r);
   bc12_seen_c:   cover property (auto_r && scheme_r == SCH_BC12);
   div2_seen_c:   cover property (auto_r && scheme_r == SCH_DIV2);

endmodule

// ===== verif/ccpm_load_model.sv
// Portable device load model driving the load comparators
`timescale 1ns/100ps
module ccpm_load_model #(
   parameter int LOW_MA = 900
) (
   input  wire logic [15:0] i_load_ma,
   output logic             o_above_trip,
   output logic             o_below_release,
   output logic             o_over_750ma
);
   // Trip points ride on the low limit setting
   assign o_above_trip    = i_load_ma > 16'(LOW_MA + 60);
   assign o_below_release = i_load_ma < 16'(LOW_MA + 10);
   assign o_over_750ma    = i_load_ma > 16'd750;
endmodule

// ===== verif/ccpm_ctrl_bench.sv
// Self-checking bench for the charge port controller
`timescale 1ns/100ps
module ccpm_ctrl_bench;
   import ccpm_pkg::*;
   logic         i_mclk;
   logic         i_nrst;
   ccpm_pins_s   p;
   ccpm_pins_s   pins;
   ccpm_mode_e   mode;
   ccpm_mode_e   m;
   ccpm_scheme_e sch;
   logic         sw;
   logic         lim;
   logic         dis;
   logic         dsw;
   logic         st_n;
   logic         f_n;
   logic         st_o;
   logic         f_o;
   logic         xp;
   ccpm_scheme_e sx;
   logic         ab;
   logic         bl;
   logic         ov;
   logic [15:0]  load;
   logic [3:0]   c;
   int           fail_count;
   int           total_checks;

   ccpm_ctrl #(.ASSERT_CYC(20), .RELEASE_CYC(40), .DEGLITCH_CYC(6),
      .DISCH_CYC(28'd5), .V12_CYC(28'd4)) dut (
      .i_mclk(i_mclk), .i_nrst(i_nrst), .i_pins(pins), .o_mode(mode),
      .o_scheme(sch), .o_switch_on(sw), .o_limit_high(lim),
      .o_discharge(dis), .o_data_sw_on(dsw), .o_status_o(st_o),
      .o_status_oe_n(st_n), .o_fault_o(f_o), .o_fault_oe_n(f_n));

   ccpm_load_model model (.i_load_ma(load), .o_above_trip(ab),
      .o_below_release(bl), .o_over_750ma(ov));

   always_comb begin
      pins = p;
      pins.load_above_trip = ab;
      pins.load_below_release = bl;
      pins.over_750ma = ov;
   end

   initial begin
      i_mclk = 0;
      forever #10 i_mclk = ~i_mclk;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic ccpm_mode_e em(logic [3:0] k);
      case (k[3:1])
         3'h0: return M_DISCHARGE;
         3'h1, 3'h3: return M_AUTOMATIC_DEDICATED_MODE;
         3'h2, 3'h6: return M_SDP_BASIC;
         3'h4: return M_FORCED_SHORTED_DEDICATED_MODE;
         3'h5: return M_DCP_DIV1;
         default: return k[0] ? M_CDP : M_SDP_ALT;
      endcase
   endfunction

   task chk(string n, logic [7:0] e, logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %0h seen %0h", n, e, s);
      end
   endtask

   task cyc(int n);
      repeat (n) @(negedge i_mclk);
   endtask

   task setc(logic [3:0] k);
      {p.control_pin_one, p.control_pin_two, p.control_pin_three,
         p.limit_select_input} = k;
      cyc(15);
   endtask

   // Polls each cycle, so short-lived schemes are not missed
   task seek(ccpm_scheme_e s);
      int k;
      k = 0;
      while (sch !== s && k < 60) begin
         cyc(1);
         k++;
      end
      chk("scheme", s, sch);
   endtask

   task test_done;
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      cyc(20000);
      fail_count++;
      test_done;
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      i_nrst = 0;
      p = '0;
      load = 16'd500;
      p.vin_above_on = 1;
      p.vin_above_off = 1;
      p.temp_cooled = 1;
      p.enable = 1;
      fail_count = 0;
      total_checks = 0;
      void'($urandom(95));
      cyc(3);
      i_nrst = 1;
      for (int i = 0; i < 36; i++) begin
         c = (i < 16) ? i[3:0] : 4'($urandom);
         p.enable = (i < 16) | 1'($urandom);
         setc(c);
         m = em(c);
         chk("mode", m, mode);
         xp = (m == M_SDP_BASIC || m == M_SDP_ALT || m == M_CDP) & p.enable;
         chk("data_sw", xp, dsw);
         chk("discharge", m == M_DISCHARGE, dis);
         xp = (m == M_CDP || m == M_AUTOMATIC_DEDICATED_MODE) | c[0];
         if (m != M_DISCHARGE)
            chk("limit", xp, lim);
         sx = (m == M_FORCED_SHORTED_DEDICATED_MODE) ? SCH_BC12 : SCH_NONE;
         if (m == M_DCP_DIV1 || m == M_AUTOMATIC_DEDICATED_MODE)
            sx = SCH_DIV1;
         chk("scheme", sx, sch);
      end
      setc(4'he);
      p.limit_select_input = 1;
      for (int k = 0; k < 15; k++) begin
         cyc(1);
         chk("no_disch", 0, dis);
      end
      chk("mode", M_CDP, mode);
      // Load dips for one cycle so the qualification must start over
      load = 16'd1000;
      cyc(10);
      load = 16'd500;
      cyc(1);
      load = 16'd1000;
      cyc(18);
      chk("status", 1, st_n);
      cyc(12);
      chk("status", 0, st_n);
      chk("status_o", 0, st_o);
      load = 16'd500;
      cyc(30);
      chk("status", 0, st_n);
      cyc(20);
      chk("status", 1, st_n);
      load = 16'd930;
      p.primary_detect = 1;
      cyc(3);
      chk("status", 0, st_n);
      p.primary_detect = 0;
      load = 16'd500;
      cyc(50);
      chk("status", 1, st_n);
      // Die stays hot after the trip clears, so restart must wait
      p.temp_cooled = 0;
      p.temp_over_155 = 1;
      cyc(4);
      chk("fault", 0, f_n);
      chk("fault_o", 0, f_o);
      chk("switch", 0, sw);
      p.temp_over_155 = 0;
      cyc(5);
      chk("switch", 0, sw);
      chk("fault", 0, f_n);
      p.temp_cooled = 1;
      cyc(5);
      chk("switch", 1, sw);
      p.temp_over_135 = 1;
      cyc(5);
      chk("switch", 1, sw);
      p.in_current_limit = 1;
      cyc(4);
      chk("switch", 0, sw);
      chk("fault", 0, f_n);
      p.temp_over_135 = 0;
      p.in_current_limit = 0;
      cyc(6);
      chk("fault", 1, f_n);
      p.in_current_limit = 1;
      cyc(4);
      chk("fault", 1, f_n);
      cyc(8);
      chk("fault", 0, f_n);
      p.in_current_limit = 0;
      cyc(6);
      p.vin_above_on = 0;
      p.vin_above_off = 0;
      cyc(5);
      chk("switch", 0, sw);
      p.vin_above_off = 1;
      cyc(5);
      chk("switch", 0, sw);
      p.vin_above_on = 1;
      cyc(5);
      chk("switch", 1, sw);
      setc(4'h2);
      chk("scheme", SCH_DIV1, sch);
      p.dcp_attach = 1;
      seek(SCH_ATTACH_DISCH);
      seek(SCH_V12);
      seek(SCH_BC12);
      p.dcp_attach = 0;
      cyc(10);
      chk("scheme", SCH_BC12, sch);
      p.data_released = 1;
      seek(SCH_DIV1);
      p.data_released = 0;
      load = 16'd800;
      seek(SCH_DIV2_TEST);
      seek(SCH_DIV2);
      load = 16'd500;
      seek(SCH_DIV1);
      load = 16'd800;
      seek(SCH_DIV2_TEST);
      load = 16'd500;
      cyc(12);
      chk("scheme", SCH_DIV1, sch);
      setc(4'ha);
      load = 16'd800;
      p.dcp_attach = 1;
      cyc(20);
      chk("scheme", SCH_DIV1, sch);
      test_done;
   end
endmodule
